// File: bench/engine_model.sv
// test engine stand-in answering the block's run request
`timescale 1ns/1ns
module engine_model (
    input  wire logic        clk_sys,     // clock
    input  wire logic        test_run,    // run request
    input  wire logic [7:0]  delay,       // cycles to finish, 0 = never
    input  wire logic        fail_req,    // report a failure
    input  wire logic        unrec_req,   // failure survived retries
    output logic             test_done,   // finish pulse
    output logic             test_fail,   // failure flag
    output logic             err_unrecov, // unrecovered flag
    output logic [3:0]       fail_code,   // reason
    output logic [3:0]       fail_skey,   // sense key
    output logic [7:0]       fail_asc,    // asc
    output logic [7:0]       fail_ascq,   // ascq
    output logic [7:0]       fail_fru,    // fru
    output logic [31:0]      fail_lba     // failing lba
);
    logic [7:0] cnt;
    logic       fin;
    assign fin = test_run && delay != 8'h00 && cnt == delay;
    // detail is inverted outside the done pulse so stale values never match
    always @(posedge clk_sys) begin
        cnt <= test_run ? cnt + 8'h01 : 8'h00;
        test_done <= fin;
        test_fail <= fin & fail_req;
        err_unrecov <= fin & unrec_req;
        fail_code <= fin ? 4'h3 : 4'hc;
        fail_skey <= fin ? 4'h3 : 4'hc;
        fail_asc <= fin ? 8'h11 : 8'hee;
        fail_ascq <= fin ? 8'h02 : 8'hfd;
        fail_fru <= fin ? 8'h05 : 8'hfa;
        fail_lba <= fin ? 32'h0000_1234 : 32'hffff_edcb;
    end
endmodule : engine_model

// File: bench/tb.sv
// self-checking bench for the self-test results log
`timescale 1ns/1ns
module tb;
    logic        clk_sys = 1'b0, rst_n = 1'b0;
    logic [7:0]  s_awaddr = 8'h00, s_araddr = 8'h00, delay = 8'h00;
    logic [31:0] s_wdata = 32'h0, s_rdata, fail_lba, rd;
    logic [3:0]  s_wstrb = 4'hf, fail_code, fail_skey;
    logic        s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
    logic        s_arvalid = 1'b0, s_rready = 1'b0, bus_reset = 1'b0;
    logic        dev_reset_msg = 1'b0, fail_req = 1'b0, unrec_req = 1'b0;
    logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic        test_run, test_long, nvm_commit, irq, test_done;
    logic        test_fail, err_unrecov;
    logic [1:0]  s_bresp, s_rresp, resp;
    logic [7:0]  fail_asc, fail_ascq, fail_fru;
    logic [6:0]  hist[$];
    int          fail_count = 0, checks = 0, commits = 0;

    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (nvm_commit === 1'b1) commits <= commits + 1;

    self_test_results_log u_dut (.clk_sys, .rst_n, .s_awaddr, .s_awvalid,
        .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp,
        .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata,
        .s_rresp, .s_rvalid, .s_rready, .bus_reset, .dev_reset_msg,
        .test_done, .test_fail, .err_unrecov, .fail_code, .fail_skey,
        .fail_asc, .fail_ascq, .fail_fru, .fail_lba, .test_run, .test_long,
        .nvm_commit, .irq);
    engine_model u_eng (.clk_sys, .test_run, .delay, .fail_req, .unrec_req,
        .test_done, .test_fail, .err_unrecov, .fail_code, .fail_skey,
        .fail_asc, .fail_ascq, .fail_fru, .fail_lba);

    task automatic wrap_up;
        if (fail_count == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : wrap_up

    task automatic chk(input string what, input logic [31:0] exp, got);
        checks++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", what, exp, got);
            fail_count++;
        end
    endtask : chk

    // handshakes are judged at the negedge, where values equal the next edge
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, w, b;
        @(posedge clk_sys);
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        b = 1'b0;
        while (!b) begin
            @(negedge clk_sys);
            aw = s_awvalid & (s_awready === 1'b1);
            w = s_wvalid & (s_wready === 1'b1);
            b = (s_bvalid === 1'b1);
            resp = s_bresp;
            @(posedge clk_sys);
            if (aw) s_awvalid <= 1'b0;
            if (w) s_wvalid <= 1'b0;
        end
        s_bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a);
        logic ar, r;
        @(posedge clk_sys);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        r = 1'b0;
        while (!r) begin
            @(negedge clk_sys);
            ar = s_arvalid & (s_arready === 1'b1);
            r = (s_rvalid === 1'b1);
            rd = s_rdata;
            resp = s_rresp;
            @(posedge clk_sys);
            if (ar) s_arvalid <= 1'b0;
        end
        s_rready <= 1'b0;
    endtask : axi_rd

    task automatic lrd(input logic [7:0] idx);
        axi_wr(stl_pkg::OFS_LOGIDX, {24'h0, idx});
        axi_rd(stl_pkg::OFS_LOG0);
    endtask : lrd

    // how: 0 engine finishes, 1 abort code, 2 bus reset, 3 device reset
    task automatic one(input logic [2:0] fc, input logic [1:0] how,
                       input logic f, u, input logic [3:0] res);
        int n;
        n = commits;
        delay <= (how == 2'd0) ? 8'd40 : 8'd0;
        fail_req <= f;
        unrec_req <= u;
        axi_wr(stl_pkg::OFS_CMD, {24'h0, fc, 5'h00});
        for (int i = 0; i < 20 && test_run !== 1'b1; i++) @(negedge clk_sys);
        chk("run", 32'h1, {31'h0, test_run});
        chk("long", {31'h0, fc == stl_pkg::FC_EXT}, {31'h0, test_long});
        lrd(8'h00);
        chk("new", {25'h0, fc, stl_pkg::RES_RUN}, {25'h0, rd[6:0]});
        chk("commit", n + 1, commits);
        if (how == 2'd1) axi_wr(stl_pkg::OFS_CMD, {24'h0, 3'h4, 5'h00});
        if (how == 2'd2) bus_reset <= 1'b1;
        if (how == 2'd3) dev_reset_msg <= 1'b1;
        @(posedge clk_sys);
        bus_reset <= 1'b0;
        dev_reset_msg <= 1'b0;
        for (int i = 0; i < 200 && test_run === 1'b1; i++) @(negedge clk_sys);
        repeat (3) @(negedge clk_sys);
        hist.push_front({fc, res});
        if (hist.size() > stl_pkg::DEPTH) void'(hist.pop_back());
        lrd(8'h00);
        chk("final", {25'h0, fc, res}, {25'h0, rd[6:0]});
        chk("commit", n + 2, commits);
    endtask : one

    task automatic t_regs;
        axi_rd(stl_pkg::OFS_MASK);
        chk("mask", 32'h0, rd);
        axi_rd(stl_pkg::OFS_EXTDUR);
        chk("extdur", {16'h0, stl_pkg::EXTDUR_RST}, rd);
        axi_rd(8'h40);
        chk("rresp", {30'h0, stl_pkg::RESP_SLVERR}, {30'h0, resp});
        axi_wr(8'h40, 32'h0);
        chk("bresp", {30'h0, stl_pkg::RESP_SLVERR}, {30'h0, resp});
    endtask : t_regs

    task automatic t_pass;
        one(stl_pkg::FC_SHORT, 2'd0, 1'b0, 1'b0, 4'h0);
        chk("irq masked", 32'h0, {31'h0, irq});
        axi_rd(stl_pkg::OFS_INT);
        chk("int done", 32'h1, rd);
    endtask : t_pass

    task automatic t_fail;
        one(stl_pkg::FC_SHORT, 2'd0, 1'b1, 1'b0, 4'h0);
        one(stl_pkg::FC_EXT, 2'd0, 1'b1, 1'b1, 4'h3);
        chk("log0", 32'h0011_0323, rd);
        axi_rd(stl_pkg::OFS_LOG1);
        chk("log1", 32'h0000_0502, rd);
        axi_rd(stl_pkg::OFS_LOGLBA);
        chk("lba", 32'h0000_1234, rd);
    endtask : t_fail

    task automatic t_abort;
        axi_rd(stl_pkg::OFS_INT);
        axi_wr(stl_pkg::OFS_MASK, 32'h3);
        one(stl_pkg::FC_EXT, 2'd1, 1'b0, 1'b0, 4'h1);
        chk("irq", 32'h1, {31'h0, irq});
        axi_rd(stl_pkg::OFS_INT);
        chk("int abort", 32'h2, rd);
        repeat (3) @(negedge clk_sys);
        chk("irq clear", 32'h0, {31'h0, irq});
    endtask : t_abort

    task automatic t_resets;
        one(stl_pkg::FC_SHORT, 2'd2, 1'b0, 1'b0, 4'h2);
        one(stl_pkg::FC_EXT, 2'd3, 1'b0, 1'b0, 4'h2);
    endtask : t_resets

    task automatic t_depth;
        axi_rd(stl_pkg::OFS_STAT);
        chk("count", hist.size(), {26'h0, rd[13:8]});
        for (int i = 0; i < 15; i++)
            one(i[0] ? stl_pkg::FC_EXT : stl_pkg::FC_SHORT, 2'd2, 1'b0, 1'b0,
                4'h2);
        axi_rd(stl_pkg::OFS_STAT);
        chk("count", 32'd20, {26'h0, rd[13:8]});
        for (int i = 0; i < 20; i++) begin
            lrd(i[7:0]);
            chk("entry", {25'h0, hist[i]}, {25'h0, rd[6:0]});
        end
        lrd(8'd20);
        chk("beyond", 32'h0, rd);
    endtask : t_depth

    initial begin
        repeat (30000) @(posedge clk_sys);
        fail_count++;
        wrap_up();
    end

    initial begin
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_regs();
        t_pass();
        t_fail();
        t_abort();
        t_resets();
        t_depth();
        wrap_up();
    end
endmodule : tb

// File: rtl/hist_mem.sv
// history storage: one write port, registered read port
`timescale 1ns/1ns
module hist_mem #(
    parameter int W  = 67,
    parameter int D  = 20,
    parameter int AW = 5
) (
    input  wire logic          clk_sys, // clock
    input  wire logic          rst_n,   // async reset, low
    input  wire logic          we,      // write strobe
    input  wire logic [AW-1:0] wa,      // write address
    input  wire logic [W-1:0]  wd,      // write data
    input  wire logic [AW-1:0] ra,      // read address
    output logic      [W-1:0]  rd       // read data, registered
);
    logic [W-1:0] mem [D];

    always_ff @(posedge clk_sys) begin
        if (we) begin
            mem[wa] <= wd;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd <= '0;
        end else begin
            rd <= mem[ra];
        end
    end
endmodule : hist_mem

// File: rtl/irq_unit.sv
// sticky event status, read clear, mask, level interrupt
`timescale 1ns/1ns
module irq_unit #(
    parameter int N = 2
) (
    input  wire logic         clk_sys, // clock
    input  wire logic         rst_n,   // async reset, low
    input  wire logic [N-1:0] ev,      // event pulses
    input  wire logic         clr,     // status read clears
    input  wire logic [N-1:0] mask,    // enable per bit
    output logic      [N-1:0] status,  // sticky bits
    output logic              irq      // level interrupt
);
    logic [N-1:0] next_status;

    // an event in the clearing cycle survives the clear
    always_comb begin
        next_status = ev | (clr ? '0 : status);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            status <= '0;
            irq    <= 1'b0;
        end else begin
            status <= next_status;
            irq    <= |(next_status & mask);
        end
    end
endmodule : irq_unit

// File: rtl/self_test_results_log.sv
// self-test results history with axi4-lite register access
`timescale 1ns/1ns
module self_test_results_log #(
    parameter int HIST_DEPTH = stl_pkg::DEPTH,
    parameter logic [15:0] EXT_DURATION = stl_pkg::EXTDUR_RST
) (
    input  wire logic        clk_sys,       // clock
    input  wire logic        rst_n,         // async reset, low
    input  wire logic [7:0]  s_awaddr,      // write address
    input  wire logic        s_awvalid,     // write addr valid
    output logic             s_awready,     // write addr ready
    input  wire logic [31:0] s_wdata,       // write data
    input  wire logic [3:0]  s_wstrb,       // byte strobes
    input  wire logic        s_wvalid,      // write data valid
    output logic             s_wready,      // write data ready
    output logic [1:0]       s_bresp,       // write response
    output logic             s_bvalid,      // response valid
    input  wire logic        s_bready,      // response ready
    input  wire logic [7:0]  s_araddr,      // read address
    input  wire logic        s_arvalid,     // read addr valid
    output logic             s_arready,     // read addr ready
    output logic [31:0]      s_rdata,       // read data
    output logic [1:0]       s_rresp,       // read response
    output logic             s_rvalid,      // read data valid
    input  wire logic        s_rready,      // read data ready
    input  wire logic        bus_reset,     // bus reset seen
    input  wire logic        dev_reset_msg, // device reset msg
    input  wire logic        test_done,     // engine finished
    input  wire logic        test_fail,     // failure found
    input  wire logic        err_unrecov,   // error not recovered
    input  wire logic [3:0]  fail_code,     // engine fail reason
    input  wire logic [3:0]  fail_skey,     // sense key
    input  wire logic [7:0]  fail_asc,      // asc
    input  wire logic [7:0]  fail_ascq,     // ascq
    input  wire logic [7:0]  fail_fru,      // fru
    input  wire logic [31:0] fail_lba,      // failing lba
    output logic             test_run,      // engine may run
    output logic             test_long,     // extended variant
    output logic             nvm_commit,    // store history
    output logic             irq            // interrupt level
);
    localparam int AW = $clog2(HIST_DEPTH);
    localparam logic [AW:0] DEPTH_C = (AW+1)'(HIST_DEPTH);

    typedef enum logic [1:0] {
        ST_IDLE, ST_START, ST_RUN, ST_FINAL
    } state_e;

    function automatic logic [AW-1:0] ring_add(
        input logic [AW-1:0] a,
        input logic [AW-1:0] b
    );
        logic [AW:0] s;
        s = {1'b0, a} + {1'b0, b};
        if (s >= DEPTH_C) begin
            s = s - DEPTH_C;
        end
        return s[AW-1:0];
    endfunction : ring_add

    state_e          state;
    state_e          next_state;
    logic [AW-1:0]   head;
    logic [AW:0]     count;
    logic [AW-1:0]   log_idx;
    logic [1:0]      mask;
    stl_pkg::entry_s cur;
    stl_pkg::entry_s rd_ent;
    logic [stl_pkg::ENTRY_W-1:0] rd_raw;
    logic [AW-1:0]   new_head;
    logic            mem_we;
    logic [AW-1:0]   mem_wa;
    logic [7:0]      aw_addr;
    logic [31:0]     w_data;
    logic [3:0]      w_strb;
    logic            aw_got;
    logic            w_got;
    logic            wr_fire;
    logic            next_aw_got;
    logic            next_w_got;
    logic            next_bvalid;
    logic            next_rvalid;
    logic [7:0]      ar_addr;
    logic            r_pend;
    logic            cmd_wr;
    logic [2:0]      cmd_fc;
    logic            start_req;
    logic            abort_req;
    logic            reset_ev;
    logic            log_ok;
    logic [1:0]      int_stat;
    logic [1:0]      int_ev;
    logic            int_clr;
    logic [31:0]     next_rdata;
    logic            next_rerr;

    // write channel: address and data taken in either order
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            aw_got   <= 1'b0;
            w_got    <= 1'b0;
            aw_addr  <= '0;
            w_data   <= '0;
            w_strb   <= '0;
            s_bvalid <= 1'b0;
            s_bresp  <= stl_pkg::RESP_OKAY;
            s_awready <= 1'b0;
            s_wready  <= 1'b0;
        end else begin
            // readies are flops, so they follow the next holding state
            s_awready <= !next_aw_got && !next_bvalid;
            s_wready  <= !next_w_got && !next_bvalid;
            if (s_awvalid && s_awready) begin
                aw_got  <= 1'b1;
                aw_addr <= s_awaddr;
            end
            if (s_wvalid && s_wready) begin
                w_got  <= 1'b1;
                w_data <= s_wdata;
                w_strb <= s_wstrb;
            end
            if (wr_fire) begin
                aw_got   <= 1'b0;
                w_got    <= 1'b0;
                s_bvalid <= 1'b1;
                s_bresp  <= (aw_addr > stl_pkg::OFS_LOGIDX) ?
                            stl_pkg::RESP_SLVERR : stl_pkg::RESP_OKAY;
            end else if (s_bready) begin
                s_bvalid <= 1'b0;
            end
        end
    end

    always_comb begin
        wr_fire     = aw_got && w_got && !s_bvalid;
        next_aw_got = !wr_fire && (aw_got || (s_awvalid && s_awready));
        next_w_got  = !wr_fire && (w_got || (s_wvalid && s_wready));
        next_bvalid = wr_fire || (s_bvalid && !s_bready);
        cmd_wr    = wr_fire && w_strb[0] && aw_addr == stl_pkg::OFS_CMD;
        cmd_fc    = w_data[stl_pkg::CMD_FC_LSB +: 3];
        reset_ev  = bus_reset || dev_reset_msg;
        start_req = cmd_wr && state == ST_IDLE
                    && (cmd_fc == stl_pkg::FC_SHORT
                        || cmd_fc == stl_pkg::FC_EXT);
        // abort outside a running test is ignored
        abort_req = cmd_wr && cmd_fc == stl_pkg::FC_ABORT
                    && state == ST_RUN;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mask    <= stl_pkg::MASK_RST;
            log_idx <= '0;
        end else if (wr_fire && w_strb[0]) begin
            if (aw_addr == stl_pkg::OFS_MASK) begin
                mask <= w_data[1:0];
            end
            if (aw_addr == stl_pkg::OFS_LOGIDX) begin
                log_idx <= w_data[AW-1:0];
            end
        end
    end

    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE:  if (start_req) next_state = ST_START;
            ST_START: next_state = reset_ev ? ST_FINAL : ST_RUN;
            ST_RUN:   if (reset_ev || abort_req || test_done) begin
                next_state = ST_FINAL;
            end
            ST_FINAL: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state      <= ST_IDLE;
            test_run   <= 1'b0;
            nvm_commit <= 1'b0;
        end else begin
            state      <= next_state;
            test_run   <= next_state == ST_RUN;
            // storage commit follows each history write
            nvm_commit <= mem_we;
        end
    end

    // current block: function code, result and failure detail
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cur       <= '0;
            test_long <= 1'b0;
        end else if (start_req) begin
            cur       <= '0;
            cur.fc    <= cmd_fc;
            cur.res   <= stl_pkg::RES_RUN;
            test_long <= cmd_fc == stl_pkg::FC_EXT;
        end else if (state == ST_START && reset_ev) begin
            cur.res <= stl_pkg::RES_RESET;
        end else if (state == ST_RUN) begin
            if (reset_ev) begin
                cur.res <= stl_pkg::RES_RESET;
            end else if (abort_req) begin
                cur.res <= stl_pkg::RES_ABORT;
            end else if (test_done) begin
                // retried and recovered errors still pass
                if (test_fail && err_unrecov) begin
                    cur.res  <= (fail_code == stl_pkg::RES_PASS
                                 || fail_code == stl_pkg::RES_RUN)
                                ? stl_pkg::RES_FAIL : fail_code;
                    cur.skey <= fail_skey;
                    cur.asc  <= fail_asc;
                    cur.ascq <= fail_ascq;
                    cur.fru  <= fail_fru;
                    cur.lba  <= fail_lba;
                end else begin
                    cur.res <= stl_pkg::RES_PASS;
                end
            end
        end
    end

    // ring: head moves back one slot so older blocks age
    always_comb begin
        new_head = ring_add(head, AW'(HIST_DEPTH - 1));
        mem_we   = state == ST_START || state == ST_FINAL;
        mem_wa   = (state == ST_START) ? new_head : head;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            head  <= '0;
            count <= '0;
        end else if (state == ST_START) begin
            head <= new_head;
            // full ring: the new block overwrites the oldest
            if (count != DEPTH_C) begin
                count <= count + 1'b1;
            end
        end
    end

    hist_mem #(
        .W  (stl_pkg::ENTRY_W),
        .D  (HIST_DEPTH),
        .AW (AW)
    ) u_mem (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .we      (mem_we),
        .wa      (mem_wa),
        .wd      (cur),
        .ra      (ring_add(head, log_idx)),
        .rd      (rd_raw)
    );

    always_comb begin
        int_ev = '0;
        if (state == ST_FINAL) begin
            if (cur.res == stl_pkg::RES_ABORT
                || cur.res == stl_pkg::RES_RESET) begin
                int_ev[stl_pkg::INT_ABORT] = 1'b1;
            end else begin
                int_ev[stl_pkg::INT_DONE] = 1'b1;
            end
        end
        int_clr = r_pend && ar_addr == stl_pkg::OFS_INT;
    end

    irq_unit #(
        .N (stl_pkg::INT_W)
    ) u_irq (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .ev      (int_ev),
        .clr     (int_clr),
        .mask    (mask),
        .status  (int_stat),
        .irq     (irq)
    );

    // read data mux; slots beyond the fill level read zero
    always_comb begin
        rd_ent     = rd_raw;
        log_ok     = {1'b0, log_idx} < count;
        next_rdata = '0;
        next_rerr  = 1'b0;
        unique case (ar_addr)
            stl_pkg::OFS_CMD:    next_rdata = '0;
            stl_pkg::OFS_STAT: begin
                next_rdata[stl_pkg::STAT_BUSY] = state != ST_IDLE;
                next_rdata[stl_pkg::STAT_LONG] = test_long;
                next_rdata[stl_pkg::STAT_CNT +: AW+1] = count;
            end
            stl_pkg::OFS_INT:    next_rdata[1:0] = int_stat;
            stl_pkg::OFS_MASK:   next_rdata[1:0] = mask;
            stl_pkg::OFS_EXTDUR: next_rdata[15:0] = EXT_DURATION;
            stl_pkg::OFS_LOGIDX: next_rdata[AW-1:0] = log_idx;
            stl_pkg::OFS_LOG0: if (log_ok) begin
                next_rdata[3:0]   = rd_ent.res;
                next_rdata[6:4]   = rd_ent.fc;
                next_rdata[11:8]  = rd_ent.skey;
                next_rdata[23:16] = rd_ent.asc;
            end
            stl_pkg::OFS_LOG1: if (log_ok) begin
                next_rdata[7:0]  = rd_ent.ascq;
                next_rdata[15:8] = rd_ent.fru;
            end
            stl_pkg::OFS_LOGLBA: if (log_ok) begin
                next_rdata = rd_ent.lba;
            end
            default: next_rerr = 1'b1;
        endcase
    end

    // one spare cycle lets the history read port settle
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ar_addr  <= '0;
            r_pend   <= 1'b0;
            s_rvalid <= 1'b0;
            s_rdata  <= '0;
            s_rresp  <= stl_pkg::RESP_OKAY;
        end else if (s_arvalid && s_arready) begin
            ar_addr <= s_araddr;
            r_pend  <= 1'b1;
        end else if (r_pend) begin
            r_pend   <= 1'b0;
            s_rvalid <= 1'b1;
            s_rdata  <= next_rdata;
            s_rresp  <= next_rerr ? stl_pkg::RESP_SLVERR
                                  : stl_pkg::RESP_OKAY;
        end else if (s_rready) begin
            s_rvalid <= 1'b0;
        end
    end

    always_comb begin
        next_rvalid = r_pend || (s_rvalid && !s_rready);
    end

    // address ready held low from handshake until the data is taken
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_arready <= 1'b0;
        end else begin
            s_arready <= !(s_arvalid && s_arready) && !next_rvalid;
        end
    end

    chk_init_block: assert property (@(posedge clk_sys)
        disable iff (!rst_n) state == ST_START |->
        mem_we && cur.res == stl_pkg::RES_RUN)
        else $error("new block not marked in progress");
    chk_fc_copy: assert property (@(posedge clk_sys)
        disable iff (!rst_n) start_req |=> cur.fc == $past(cmd_fc))
        else $error("function code not copied");
    chk_init_commit: assert property (@(posedge clk_sys)
        disable iff (!rst_n) state == ST_START |=> nvm_commit)
        else $error("history not committed after init");
    chk_final_commit: assert property (@(posedge clk_sys)
        disable iff (!rst_n) state == ST_FINAL |->
        mem_we && mem_wa == head ##1 nvm_commit)
        else $error("final result not stored");
    chk_depth_cap: assert property (@(posedge clk_sys)
        disable iff (!rst_n) count <= DEPTH_C)
        else $error("history deeper than limit");
    chk_depth_grow: assert property (@(posedge clk_sys)
        disable iff (!rst_n) state == ST_START && count < DEPTH_C
        |=> count == $past(count) + 1'b1)
        else $error("history lost a block");
    chk_abort_code: assert property (@(posedge clk_sys)
        disable iff (!rst_n) abort_req && !reset_ev
        |=> state == ST_FINAL && cur.res == stl_pkg::RES_ABORT)
        else $error("abort not recorded as 01");
    chk_reset_code: assert property (@(posedge clk_sys)
        disable iff (!rst_n) state == ST_RUN && reset_ev
        |=> state == ST_FINAL && cur.res == stl_pkg::RES_RESET)
        else $error("reset not recorded as 02");
    chk_recovered: assert property (@(posedge clk_sys)
        disable iff (!rst_n) state == ST_RUN && test_done
        && !err_unrecov && !reset_ev && !abort_req
        |=> cur.res == stl_pkg::RES_PASS)
        else $error("recovered error counted as failure");
    chk_long_sel: assert property (@(posedge clk_sys)
        disable iff (!rst_n) start_req
        |=> test_long == ($past(cmd_fc) == stl_pkg::FC_EXT) ##1 test_run)
        else $error("wrong test variant");
    cov_pass: cover property (@(posedge clk_sys) disable iff (!rst_n)
        state == ST_FINAL && cur.res == stl_pkg::RES_PASS);
    cov_abort: cover property (@(posedge clk_sys) disable iff (!rst_n)
        abort_req);
    cov_reset: cover property (@(posedge clk_sys) disable iff (!rst_n)
        state == ST_RUN && reset_ev);
    cov_full: cover property (@(posedge clk_sys) disable iff (!rst_n)
        state == ST_START && count == DEPTH_C);
endmodule : self_test_results_log

// File: rtl/stl_pkg.sv
// constants and types shared by the self-test results log
// How it works
// - code 010b selects the extended test
// - code 001b selects short test, bits 7:5
// - extended test duration readable by software
// - new block inserted at head, others age
// - history holds 20 blocks, oldest dropped
// - new block takes the issued function code
// - new block result code starts at Fh
// - commit history to storage after init
// - final outcome overwrites result code, committed
// - result code 4 bits, zero means pass
// - failure stores sense key, asc, ascq, fru, lba
// - bus or device reset ends running test
// - abort code records result 01
// - other termination records result 02
// - recovered errors never count as failure
package stl_pkg;
    localparam int          DEPTH      = 20;
    localparam logic [2:0]  FC_SHORT   = 3'h1;
    localparam logic [2:0]  FC_EXT     = 3'h2;
    localparam logic [2:0]  FC_ABORT   = 3'h4;
    localparam logic [3:0]  RES_PASS   = 4'h0;
    localparam logic [3:0]  RES_ABORT  = 4'h1;
    localparam logic [3:0]  RES_RESET  = 4'h2;
    localparam logic [3:0]  RES_FAIL   = 4'h7;
    localparam logic [3:0]  RES_RUN    = 4'hf;
    localparam logic [7:0]  OFS_CMD    = 8'h00;
    localparam logic [7:0]  OFS_STAT   = 8'h04;
    localparam logic [7:0]  OFS_INT    = 8'h08;
    localparam logic [7:0]  OFS_MASK   = 8'h0c;
    localparam logic [7:0]  OFS_EXTDUR = 8'h10;
    localparam logic [7:0]  OFS_LOGIDX = 8'h14;
    localparam logic [7:0]  OFS_LOG0   = 8'h18;
    localparam logic [7:0]  OFS_LOG1   = 8'h1c;
    localparam logic [7:0]  OFS_LOGLBA = 8'h20;
    localparam int          CMD_FC_LSB = 5;
    localparam int          STAT_BUSY  = 0;
    localparam int          STAT_LONG  = 1;
    localparam int          STAT_CNT   = 8;
    localparam int          INT_W      = 2;
    localparam int          INT_DONE   = 0;
    localparam int          INT_ABORT  = 1;
    localparam logic [1:0]  MASK_RST   = 2'h0;
    localparam logic [15:0] EXTDUR_RST = 16'h0014;
    localparam logic [1:0]  RESP_OKAY  = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [31:0] lba;
        logic [7:0]  fru;
        logic [7:0]  ascq;
        logic [7:0]  asc;
        logic [3:0]  skey;
        logic [3:0]  res;
        logic [2:0]  fc;
    } entry_s;
    localparam int ENTRY_W = $bits(entry_s);
endpackage : stl_pkg
